/* File: miu_regs.svh */
// offsets, field positions and reset values of the metering interrupt unit
// included by the package users; definitions only
`ifndef MIU_REGS_SVH
`define MIU_REGS_SVH

`define MIU_ADDR_W          16
`define MIU_OFF_CURRENT_PEAK_VALUE       16'he500
`define MIU_OFF_VOLTAGE_PEAK_VALUE       16'he501
`define MIU_OFF_FLAGS0      16'he502
`define MIU_OFF_FLAGS1      16'he503
`define MIU_OFF_ENABLE0     16'he50a
`define MIU_OFF_ENABLE1     16'he50b
`define MIU_OFF_PHEVENT     16'he600
`define MIU_OFF_PHASE_NOLOAD_INDICATION    16'he608
`define MIU_OFF_PHASE_SIGN_INDICATION      16'he617
`define MIU_OFF_RESETCTL    16'he6f0

`define MIU_BIT_RESET_COMPLETE_FLAG     15
`define MIU_BIT_SAG         16
`define MIU_BIT_HIGH_I      17
`define MIU_BIT_HIGH_V      18
`define MIU_BIT_PK_I        23
`define MIU_BIT_PK_V        24
`define MIU_PEAK_PH_LSB     24
`define MIU_ENABLE_RESET    32'h0000_0000
`define MIU_FLAGS_RESET     32'h0000_0000

`endif

/* File: miu_pkg.sv */
// types of the metering interrupt unit
// shared by the unit and its flag bank
package miu_pkg;
  typedef logic [31:0] miu_word_t;
  typedef logic [2:0]  miu_ph_t;

  // phase indications that ride along with their event strobes
  typedef struct packed {
    miu_ph_t active_sign_bits;
    miu_ph_t reactive_sign_bits;
    logic    sum_sign_a;
    logic    sum_sign_b;
    logic    sum_sign_c;
    miu_ph_t total_idle_phases;
    miu_ph_t fundamental_idle_phases;
    miu_ph_t apparent_idle_phases;
    miu_ph_t dip_phases;
    miu_ph_t high_current_phases;
    miu_ph_t high_voltage_phases;
    miu_ph_t current_peak_phases;
    miu_ph_t voltage_peak_phases;
  } miu_phase_s;

  // register port request
  typedef struct packed {
    logic [15:0] addr;
    miu_word_t   wdata;
    logic        wr;
    logic        rd;
  } miu_bus_s;

  typedef enum logic [1:0] {
    MIU_RST_IDLE,
    MIU_RST_DONE,
    MIU_RST_RUN
  } miu_rst_e;
endpackage

/* File: miu_flag_bank.sv */
// one sticky status register with enable gating and its interrupt line
// events and clear masks are synchronous single-cycle pulses
`timescale 1ns/100ps
`default_nettype none
module miu_flag_bank
  import miu_pkg::*;
#(
  parameter int         WIDTH  = 32,
  parameter logic [31:0] NOMASK = 32'h0000_0000
)(
  input  wire logic   clk_sys,
  input  wire logic   resetn,
  input  wire logic [WIDTH-1:0] event_in,
  input  wire logic [WIDTH-1:0] clear_in,
  input  wire logic [WIDTH-1:0] enable_in,
  output logic [WIDTH-1:0] flags_reg,
  output logic        int_n_reg
);
  logic [WIDTH-1:0] flags_next;
  wire  [WIDTH-1:0] gate_w;
  wire              int_n_next;
  wire  [WIDTH-1:0] clr_only_w;

  // per bit: event wins over clear, zero writes leave the flag
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++)
    begin : g_bit
      assign flags_next[i] = event_in[i] |
                             (flags_reg[i] & ~clear_in[i]);
      assign gate_w[i] = enable_in[i] | NOMASK[i];
    end
  endgenerate

  // line stays low while any enabled flag is left; an enabled event after
  // release pulls it low again, a fresh falling edge
  assign int_n_next = ~|(flags_next & gate_w);

  // bits cleared this cycle with no event to keep them
  assign clr_only_w = clear_in & ~event_in;

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      flags_reg <= '0;
      int_n_reg <= 1'b1;
    end
    else
    begin
      flags_reg <= flags_next;
      int_n_reg <= int_n_next;
    end
  end

  // line moves on the same edge as the flags; an enable written this cycle
  // only reaches the line on the next edge
  hold_low_a : assert property (@(posedge clk_sys)
    disable iff (!resetn)
    |(flags_reg & gate_w & ~clear_in) |=> !int_n_reg)
    else $error("line high with an enabled flag set");
  set_wins_a : assert property (@(posedge clk_sys)
    disable iff (!resetn)
    |event_in |=> ((flags_reg & $past(event_in)) == $past(event_in)))
    else $error("event lost against clear");
  w1c_a : assert property (@(posedge clk_sys)
    disable iff (!resetn)
    |clr_only_w |=> ~|(flags_reg & $past(clr_only_w)))
    else $error("flag not cleared by a one");
  masked_high_a : assert property (@(posedge clk_sys)
    disable iff (!resetn)
    (~|(flags_reg & gate_w) && ~|event_in) |=> int_n_reg)
    else $error("line low without an enabled flag");
endmodule
`default_nettype wire

/* File: miu_unit.sv */
// metering interrupt unit: two sticky status words, two enable words,
// two active-low lines and the phase registers read with them
// assumes event strobes and phase indications arrive on clk_sys,
// one cycle pulses, and a simple register port with read data next cycle
//
// The strobed register port is this design's own decision.
`include "miu_regs.svh"
`timescale 1ns/100ps
`default_nettype none
module miu_unit
  import miu_pkg::*;
#(
  parameter int WIDTH = 32
)(
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  // register port
  input  wire logic [15:0] reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [31:0]      reg_rdata,
  // event sources
  input  wire logic [WIDTH-1:0] event_first,
  input  wire logic [WIDTH-1:0] event_second,
  input  wire logic [2:0]  idle_change,
  input  wire miu_phase_s  phase_in,
  input  wire logic [23:0] current_peak_mag,
  input  wire logic [23:0] voltage_peak_mag,
  // outputs
  output logic             int_out_first_n,
  output logic             int_out_second_n,
  output logic             soft_reset_req
);
  miu_bus_s    bus_w;
  miu_word_t   event_enable_first_reg;
  miu_word_t   event_enable_second_reg;
  miu_word_t   event_flags_first;
  miu_word_t   event_flags_second;
  logic [15:0] phase_event_reg;
  logic [15:0] phase_noload_reg;
  logic [15:0] phase_sign_reg;
  miu_word_t   current_peak_reg;
  miu_word_t   voltage_peak_reg;
  miu_word_t   reg_rdata_next;
  miu_rst_e    rst_state_reg;
  miu_rst_e    rst_state_next;
  logic        soft_reset_next;

  assign bus_w = '{addr: reg_addr, wdata: reg_wdata,
                   wr: reg_wr, rd: reg_rd};

  // address decode
  wire hit_flags0  = bus_w.addr == `MIU_OFF_FLAGS0;
  wire hit_flags1  = bus_w.addr == `MIU_OFF_FLAGS1;
  wire hit_enable0 = bus_w.addr == `MIU_OFF_ENABLE0;
  wire hit_enable1 = bus_w.addr == `MIU_OFF_ENABLE1;
  wire hit_rstctl  = bus_w.addr == `MIU_OFF_RESETCTL;
  wire wr_rstctl   = bus_w.wr & hit_rstctl & bus_w.wdata[0];

  // write-one-to-clear masks, only during a status write
  wire [WIDTH-1:0] clear_first  =
    (bus_w.wr & hit_flags0) ? bus_w.wdata : '0;
  wire [WIDTH-1:0] clear_second =
    (bus_w.wr & hit_flags1) ? bus_w.wdata : '0;

  // reset-complete is injected as a second-word event one cycle after
  // reset release or a software reset, so it cannot be lost to a clear
  wire rst_done_pulse = (rst_state_reg == MIU_RST_DONE);
  wire [WIDTH-1:0] event_second_all =
    event_second | (WIDTH'(rst_done_pulse) << `MIU_BIT_RESET_COMPLETE_FLAG);

  // idle flags also set when any phase enters or leaves idle
  wire [WIDTH-1:0] event_second_fin =
    event_second_all | WIDTH'(idle_change);

  // first word: gated by its own enable word only
  miu_flag_bank #(
    .WIDTH  (WIDTH),
    .NOMASK (32'h0000_0000)
  ) u_first (
    .clk_sys   (clk_sys),
    .resetn    (resetn),
    .event_in  (event_first),
    .clear_in  (clear_first),
    .enable_in (event_enable_first_reg),
    .flags_reg (event_flags_first),
    .int_n_reg (int_out_first_n)
  );

  // second word: the reset-complete bit ignores its enable
  miu_flag_bank #(
    .WIDTH  (WIDTH),
    .NOMASK (32'h0000_8000)
  ) u_second (
    .clk_sys   (clk_sys),
    .resetn    (resetn),
    .event_in  (event_second_fin),
    .clear_in  (clear_second),
    .enable_in (event_enable_second_reg),
    .flags_reg (event_flags_second),
    .int_n_reg (int_out_second_n)
  );

  // reset-complete sequencer
  always_comb
  begin
    rst_state_next = rst_state_reg;
    case (rst_state_reg)
      MIU_RST_IDLE: rst_state_next = MIU_RST_DONE;
      MIU_RST_DONE: rst_state_next = MIU_RST_RUN;
      MIU_RST_RUN:  if (wr_rstctl) rst_state_next = MIU_RST_DONE;
      default:      rst_state_next = MIU_RST_IDLE;
    endcase
  end
  assign soft_reset_next = wr_rstctl;

  // enable words; a software reset brings them back to zero
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      event_enable_first_reg  <= `MIU_ENABLE_RESET;
      event_enable_second_reg <= `MIU_ENABLE_RESET;
      rst_state_reg           <= MIU_RST_IDLE;
      soft_reset_req          <= 1'b0;
    end
    else
    begin
      rst_state_reg  <= rst_state_next;
      soft_reset_req <= soft_reset_next;
      if (wr_rstctl)
      begin
        event_enable_first_reg  <= `MIU_ENABLE_RESET;
        event_enable_second_reg <= `MIU_ENABLE_RESET;
      end
      else if (bus_w.wr & hit_enable0)
        event_enable_first_reg  <= bus_w.wdata;
      else if (bus_w.wr & hit_enable1)
        event_enable_second_reg <= bus_w.wdata;
    end
  end

  // phase indications load with their own flag's event, same cycle
  wire sign_load = |(event_first & 32'h0004_3fc0);
  wire ev_load   = |(event_second & 32'h0007_0000);
  wire nl_load   = |idle_change | |event_second[2:0];
  wire ip_load   = event_second[`MIU_BIT_PK_I];
  wire vp_load   = event_second[`MIU_BIT_PK_V];

  wire [15:0] sign_next = {7'h00, phase_in.sum_sign_c,
                           phase_in.sum_sign_b,
                           phase_in.reactive_sign_bits,
                           phase_in.sum_sign_a,
                           phase_in.active_sign_bits};
  wire [15:0] nl_next = {7'h00, phase_in.apparent_idle_phases,
                         phase_in.fundamental_idle_phases,
                         phase_in.total_idle_phases};
  wire [15:0] ev_next = {1'b0, phase_in.dip_phases,
                         phase_in.high_voltage_phases, 3'h0,
                         phase_in.high_current_phases, 3'h0};
  wire [31:0] ip_next = {5'h00, phase_in.current_peak_phases,
                         current_peak_mag};
  wire [31:0] vp_next = {5'h00, phase_in.voltage_peak_phases,
                         voltage_peak_mag};

  // phase registers hold until the next paired event, so the host can
  // read them before it clears the flag
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      phase_sign_reg   <= 16'h0000;
      phase_noload_reg <= 16'h0000;
      phase_event_reg  <= 16'h0000;
      current_peak_reg <= 32'h0000_0000;
      voltage_peak_reg <= 32'h0000_0000;
    end
    else
    begin
      if (sign_load) phase_sign_reg   <= sign_next;
      if (nl_load)   phase_noload_reg <= nl_next;
      if (ev_load)   phase_event_reg  <= ev_next;
      if (ip_load)   current_peak_reg <= ip_next;
      if (vp_load)   voltage_peak_reg <= vp_next;
    end
  end

  // read mux; unmapped addresses read zero
  always_comb
  begin
    reg_rdata_next = 32'h0000_0000;
    if (bus_w.rd)
    begin
      case (bus_w.addr)
        `MIU_OFF_CURRENT_PEAK_VALUE:    reg_rdata_next = current_peak_reg;
        `MIU_OFF_VOLTAGE_PEAK_VALUE:    reg_rdata_next = voltage_peak_reg;
        `MIU_OFF_FLAGS0:   reg_rdata_next = event_flags_first;
        `MIU_OFF_FLAGS1:   reg_rdata_next = event_flags_second;
        `MIU_OFF_ENABLE0:  reg_rdata_next = event_enable_first_reg;
        `MIU_OFF_ENABLE1:  reg_rdata_next = event_enable_second_reg;
        `MIU_OFF_PHEVENT:  reg_rdata_next = {16'h0000, phase_event_reg};
        `MIU_OFF_PHASE_NOLOAD_INDICATION: reg_rdata_next = {16'h0000, phase_noload_reg};
        `MIU_OFF_PHASE_SIGN_INDICATION:   reg_rdata_next = {16'h0000, phase_sign_reg};
        default:           reg_rdata_next = 32'h0000_0000;
      endcase
    end
  end

  // read data stands one cycle only, zero otherwise
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      reg_rdata <= 32'h0000_0000;
    else
      reg_rdata <= reg_rdata_next;
  end

  // checks: reset-complete, software reset and enable words
  // flag and line move on the same edge, so the host may clear at once
  rst_done_set_a : assert property (@(posedge clk_sys)
    disable iff (!resetn)
    rst_done_pulse |=> event_flags_second[`MIU_BIT_RESET_COMPLETE_FLAG]
      && !int_out_second_n)
    else $error("reset complete not flagged");
  rst_unmasked_a : assert property (@(posedge clk_sys)
    disable iff (!resetn)
    event_flags_second[`MIU_BIT_RESET_COMPLETE_FLAG] |=> !int_out_second_n
      or event_flags_second[`MIU_BIT_RESET_COMPLETE_FLAG] == 1'b0)
    else $error("reset complete did not pull line two");
  enable_reset_a : assert property (@(posedge clk_sys)
    disable iff (!resetn)
    $rose(soft_reset_req) |-> event_enable_first_reg == 32'h0000_0000
      && event_enable_second_reg == 32'h0000_0000)
    else $error("enables not zero after reset");
  soft_pulse_a : assert property (@(posedge clk_sys)
    disable iff (!resetn)
    (wr_rstctl && rst_state_reg == MIU_RST_RUN) |=> soft_reset_req
      && rst_done_pulse)
    else $error("software reset did not restart");
  enable_write_a : assert property (@(posedge clk_sys)
    disable iff (!resetn)
    (reg_wr && hit_enable0 && !wr_rstctl)
      |=> event_enable_first_reg == $past(reg_wdata))
    else $error("enable word not written");

  // checks: lines, flags and the read port
  first_line_a : assert property (@(posedge clk_sys)
    disable iff (!resetn)
    |(event_first & event_enable_first_reg) |=> !int_out_first_n)
    else $error("line one not pulled low");
  second_line_a : assert property (@(posedge clk_sys)
    disable iff (!resetn)
    |(event_second_fin & event_enable_second_reg) |=> !int_out_second_n)
    else $error("line two not pulled low");
  unmasked_set_a : assert property (@(posedge clk_sys)
    disable iff (!resetn)
    (event_first[6] && !event_enable_first_reg[6]) |=> event_flags_first[6])
    else $error("disabled event did not set its flag");
  flags_read_a : assert property (@(posedge clk_sys)
    disable iff (!resetn)
    (reg_rd && hit_flags1) |=> reg_rdata == $past(event_flags_second))
    else $error("second status word misread");
  read_once_a : assert property (@(posedge clk_sys)
    disable iff (!resetn)
    !reg_rd |=> reg_rdata == 32'h0000_0000)
    else $error("read data outside its cycle");

  // checks: phase registers load on the edge that sets their flag
  sign_pair_a : assert property (@(posedge clk_sys)
    disable iff (!resetn)
    event_first[6]
      |=> phase_sign_reg[2:0] == $past(phase_in.active_sign_bits))
    else $error("sign bits not captured");
  react_pair_a : assert property (@(posedge clk_sys)
    disable iff (!resetn)
    event_first[10]
      |=> phase_sign_reg[6:4] == $past(phase_in.reactive_sign_bits))
    else $error("reactive sign bits not captured");
  sum_pair_a : assert property (@(posedge clk_sys)
    disable iff (!resetn)
    event_first[9] |=> phase_sign_reg[3] == $past(phase_in.sum_sign_a))
    else $error("first sum sign not captured");
  sum_last_pair_a : assert property (@(posedge clk_sys)
    disable iff (!resetn)
    event_first[18] |=> phase_sign_reg[8] == $past(phase_in.sum_sign_c))
    else $error("last sum sign not captured");
  idle_pair_a : assert property (@(posedge clk_sys)
    disable iff (!resetn)
    idle_change[0] |=> event_flags_second[0]
      && phase_noload_reg[2:0] == $past(phase_in.total_idle_phases))
    else $error("idle flag and field out of step");
  fund_idle_a : assert property (@(posedge clk_sys)
    disable iff (!resetn)
    idle_change[1] |=> event_flags_second[1]
      && phase_noload_reg[5:3] == $past(phase_in.fundamental_idle_phases))
    else $error("fundamental idle field out of step");
  app_idle_a : assert property (@(posedge clk_sys)
    disable iff (!resetn)
    idle_change[2] |=> event_flags_second[2]
      && phase_noload_reg[8:6] == $past(phase_in.apparent_idle_phases))
    else $error("apparent idle field out of step");
  dip_pair_a : assert property (@(posedge clk_sys)
    disable iff (!resetn)
    event_second[`MIU_BIT_SAG]
      |=> phase_event_reg[14:12] == $past(phase_in.dip_phases))
    else $error("dip phases not captured");
  high_i_pair_a : assert property (@(posedge clk_sys)
    disable iff (!resetn)
    event_second[`MIU_BIT_HIGH_I]
      |=> phase_event_reg[5:3] == $past(phase_in.high_current_phases))
    else $error("high current phases not captured");
  high_v_pair_a : assert property (@(posedge clk_sys)
    disable iff (!resetn)
    event_second[`MIU_BIT_HIGH_V]
      |=> phase_event_reg[11:9] == $past(phase_in.high_voltage_phases))
    else $error("high voltage phases not captured");
  peak_pair_a : assert property (@(posedge clk_sys)
    disable iff (!resetn)
    event_second[`MIU_BIT_PK_I]
      |=> current_peak_reg[26:24] == $past(phase_in.current_peak_phases))
    else $error("current peak phases not captured");
  voltage_peak_value_pair_a : assert property (@(posedge clk_sys)
    disable iff (!resetn)
    event_second[`MIU_BIT_PK_V]
      |=> voltage_peak_reg[26:24] == $past(phase_in.voltage_peak_phases))
    else $error("voltage peak phases not captured");
endmodule
`default_nettype wire

/* File: miu_host_model.sv */
// host model: serves one interrupt line and lends its bus tasks
// assumes read data stand in the cycle after the read strobe
`include "miu_regs.svh"
`timescale 1ns/100ps
`default_nettype none
module miu_host_model
#(
  parameter logic [15:0] FLAGS_ADDR = `MIU_OFF_FLAGS1,
  parameter logic [15:0] PH_ADDR    = `MIU_OFF_PHASE_NOLOAD_INDICATION,
  parameter logic [31:0] PAIR_MASK  = 32'h0000_0007,
  parameter int          RET_CYC    = 6
)(
  input  wire logic        clk_sys,
  input  wire logic        int_n,
  input  wire logic        svc_en,
  input  wire logic [31:0] reg_rdata,
  output logic      [15:0] reg_addr,
  output logic      [31:0] reg_wdata,
  output logic             reg_wr,
  output logic             reg_rd,
  output int               n_served,
  output logic      [31:0] seen_flags,
  output logic      [31:0] seen_phase
);
  logic        edge_seen;
  logic [31:0] tmp;

  // all tasks return just after a rising edge with nothing pending
  task automatic bus_write(input logic [15:0] a, input logic [31:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    @(posedge clk_sys);
  endtask

  // data sampled at the falling edge, well clear of the update
  task automatic bus_read(input logic [15:0] a, output logic [31:0] d);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(negedge clk_sys);
    d = reg_rdata;
    @(posedge clk_sys);
  endtask

  initial
  begin
    reg_addr   = 16'h0000;
    reg_wdata  = 32'h0;
    reg_wr     = 1'b0;
    reg_rd     = 1'b0;
    n_served   = 0;
    edge_seen  = 1'b0;
    seen_flags = 32'h0;
    seen_phase = 32'h0;
  end

  // falling edge latched like an external interrupt flag
  always @(negedge int_n) edge_seen = 1'b1;

  // service routine; a pending edge brings it back
  always
  begin
    @(posedge clk_sys);
    if (!svc_en)
      edge_seen = 1'b0;
    else if (edge_seen)
    begin
      edge_seen = 1'b0; // cleared before status read
      bus_read(FLAGS_ADDR, tmp);
      seen_flags = tmp;
      if ((tmp & PAIR_MASK) != 32'h0)
        bus_read(PH_ADDR, seen_phase);
      bus_write(FLAGS_ADDR, tmp); // exact copy back
      n_served = n_served + 1;
      repeat (RET_CYC) @(posedge clk_sys);
    end
  end
endmodule
`default_nettype wire

/* File: metering_interrupt_unit_test.sv */
// self-checking bench of the metering interrupt unit
// assumes the host model owns the register port
`include "miu_regs.svh"
`timescale 1ns/100ps
`default_nettype none
module metering_interrupt_unit_test
  import miu_pkg::*;
;
  logic        clk_sys, resetn, svc_en, i1_n, i2_n, srst;
  logic [31:0] ev1, ev2, rdata, wdata, seen_f, seen_p;
  logic [15:0] addr;
  logic        wr, rd;
  logic [2:0]  idle;
  logic [23:0] imag, vmag;
  miu_phase_s  ph;
  int          fail_count, n_compared, served;

  miu_unit i_dut (.clk_sys(clk_sys), .resetn(resetn), .reg_addr(addr),
    .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata),
    .event_first(ev1), .event_second(ev2), .idle_change(idle),
    .phase_in(ph), .current_peak_mag(imag), .voltage_peak_mag(vmag),
    .int_out_first_n(i1_n), .int_out_second_n(i2_n),
    .soft_reset_req(srst));

  miu_host_model i_host (.clk_sys(clk_sys), .int_n(i2_n), .svc_en(svc_en),
    .reg_rdata(rdata), .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr),
    .reg_rd(rd), .n_served(served), .seen_flags(seen_f),
    .seen_phase(seen_p));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop;
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // one-cycle event strobes
  task automatic pulse(input logic [31:0] a, input logic [31:0] b,
                       input logic [2:0] c);
    ev1  <= a;
    ev2  <= b;
    idle <= c;
    @(posedge clk_sys);
    ev1  <= 32'h0;
    ev2  <= 32'h0;
    idle <= 3'b000;
    @(posedge clk_sys);
  endtask

  task automatic lines(input logic e1, input logic e2);
    @(negedge clk_sys);
    check({30'h0, i1_n, i2_n}, {30'h0, e1, e2});
    @(posedge clk_sys);
  endtask

  task automatic rdchk(input logic [15:0] a, input logic [31:0] exp);
    logic [31:0] v;
    i_host.bus_read(a, v);
    check(v, exp);
  endtask

  task automatic t_reset;
    rdchk(`MIU_OFF_ENABLE0, 32'h0);
    rdchk(`MIU_OFF_ENABLE1, 32'h0);
    rdchk(`MIU_OFF_FLAGS1, 32'h0000_8000);
    lines(1'b1, 1'b0);
    i_host.bus_write(`MIU_OFF_FLAGS1, 32'h0000_8000);
    lines(1'b1, 1'b1);
  endtask

  task automatic t_gate;
    pulse(32'h0000_0080, 32'h0, 3'b000);
    lines(1'b1, 1'b1);
    rdchk(`MIU_OFF_FLAGS0, 32'h0000_0080);
    i_host.bus_write(`MIU_OFF_ENABLE0, 32'h0000_0080);
    lines(1'b0, 1'b1);
    i_host.bus_write(`MIU_OFF_FLAGS0, 32'h0);
    lines(1'b0, 1'b1);
    // clear and recurrence on the same edge: the event must win
    fork
      i_host.bus_write(`MIU_OFF_FLAGS0, 32'h0000_0080);
      pulse(32'h0000_0080, 32'h0, 3'b000);
    join
    rdchk(`MIU_OFF_FLAGS0, 32'h0000_0080);
    pulse(32'h0000_0140, 32'h0, 3'b000);
    i_host.bus_write(`MIU_OFF_ENABLE0, 32'h0000_01c0);
    i_host.bus_write(`MIU_OFF_FLAGS0, 32'h0000_00c0);
    lines(1'b0, 1'b1);
    i_host.bus_write(`MIU_OFF_FLAGS0, 32'h0000_0100);
    lines(1'b1, 1'b1);
    i_host.bus_write(`MIU_OFF_ENABLE0, 32'h0);
  endtask

  task automatic t_pair;
    logic [31:0] v;
    ph <= {3'b101, 3'b011, 1'b1, 1'b0, 1'b1, 3'b110, 3'b001, 3'b010,
           3'b100, 3'b011, 3'b110, 3'b101, 3'b010};
    pulse(32'h0004_3fc0, 32'h0187_0000, 3'b111);
    rdchk(`MIU_OFF_FLAGS0, 32'h0004_3fc0);
    rdchk(`MIU_OFF_FLAGS1, 32'h0187_0007);
    rdchk(`MIU_OFF_PHASE_SIGN_INDICATION, 32'h0000_013d);
    rdchk(`MIU_OFF_PHASE_NOLOAD_INDICATION, 32'h0000_008e);
    rdchk(`MIU_OFF_PHEVENT, 32'h0000_4c18);
    i_host.bus_read(`MIU_OFF_CURRENT_PEAK_VALUE, v);
    check({29'h0, v[26:24]}, 32'h5);
    i_host.bus_read(`MIU_OFF_VOLTAGE_PEAK_VALUE, v);
    check({29'h0, v[26:24]}, 32'h2);
    i_host.bus_write(`MIU_OFF_FLAGS0, 32'h0004_3fc0);
    i_host.bus_write(`MIU_OFF_FLAGS1, 32'h0187_0007);
    lines(1'b1, 1'b1);
    rdchk(`MIU_OFF_FLAGS0, 32'h0);
    rdchk(`MIU_OFF_FLAGS1, 32'h0);
  endtask

  // host serves line two; a second event arrives before it returns
  task automatic t_service;
    int k;
    i_host.bus_write(`MIU_OFF_ENABLE1, 32'h0001_0001);
    svc_en <= 1'b1;
    ph.total_idle_phases <= 3'b011;
    pulse(32'h0, 32'h0, 3'b001);
    for (k = 0; k < 60 && served < 1; k++) @(posedge clk_sys);
    pulse(32'h0, 32'h0001_0000, 3'b000);
    for (k = 0; k < 60 && served < 2; k++) @(posedge clk_sys);
    svc_en <= 1'b0;
    check(served, 2);
    check(seen_f, 32'h0001_0000);
    check({29'h0, seen_p[2:0]}, 32'h3);
    lines(1'b1, 1'b1);
    rdchk(`MIU_OFF_FLAGS1, 32'h0);
  endtask

  task automatic t_misc;
    rdchk(16'h0000, 32'h0);
    i_host.bus_write(`MIU_OFF_PHASE_SIGN_INDICATION, 32'h0000_ffff);
    rdchk(`MIU_OFF_PHASE_SIGN_INDICATION, 32'h0000_013d);
    i_host.bus_write(`MIU_OFF_ENABLE0, 32'h0000_00ff);
    // request pulse stands only in the cycle after the write edge
    fork
      i_host.bus_write(`MIU_OFF_RESETCTL, 32'h0000_0001);
      begin
        @(posedge clk_sys);
        @(negedge clk_sys);
        check({31'h0, srst}, 32'h1);
      end
    join
    repeat (4) @(posedge clk_sys);
    check({31'h0, srst}, 32'h0);
    rdchk(`MIU_OFF_ENABLE0, 32'h0);
    rdchk(`MIU_OFF_FLAGS1, 32'h0000_8000);
    lines(1'b1, 1'b0);
  endtask

  // 8 ns clock
  initial
  begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  // hang guard, far beyond the hundred-odd cycles the run needs
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    fail_count++;
    report_and_stop;
  end

  initial
  begin
    fail_count = 0;
    n_compared = 0;
    resetn = 1'b0;
    svc_en = 1'b0;
    ev1 = 32'h0;
    ev2 = 32'h0;
    idle = 3'b000;
    ph = '0;
    imag = 24'h123456;
    vmag = 24'habcdef;
    repeat (3) @(posedge clk_sys);
    resetn <= 1'b1;
    repeat (4) @(posedge clk_sys);
    t_reset;
    t_gate;
    t_pair;
    t_service;
    t_misc;
    report_and_stop;
  end
endmodule
`default_nettype wire
